// File: clkdiv_pkg.sv
package clkdiv_pkg;
	localparam logic [7:0] ADDR_WAKE = 8'hc6;
	localparam logic [7:0] ADDR_RATIO = 8'hc7;
	localparam logic [7:0] WAKE_RESET = 8'h00;
	localparam logic [7:0] RATIO_RESET = 8'h00;
	localparam int WAKE_EX0_BIT = 0;
	localparam int WAKE_EX1_BIT = 1;
	localparam int WAKE_WDT_BIT = 2;
	localparam int MODE_LSB = 4;
	localparam int MODE_MSB = 5;
	localparam int SEL_MSB = 2;
	localparam logic [7:0] WAKE_MASK = 8'h07;
	localparam int DIV_CNT_W = 12;
	typedef enum logic [1:0] {
		MODE_NORMAL = 2'b00,
		MODE_IMMEDIATE = 2'b01,
		MODE_DELAY = 2'b10,
		MODE_RESERVED = 2'b11
	} ratio_mode_t;
	typedef enum logic [1:0] {
		DLY_IDLE = 2'b00,
		DLY_ARMED = 2'b01,
		DLY_DIVIDING = 2'b10,
		DLY_WAIT_OVF = 2'b11
	} delay_state_t;
endpackage : clkdiv_pkg

// File: div_ctl_if.sv
interface div_ctl_if;
	logic dividing;
	logic [2:0] ratio_select;
	logic clk_enable;
	modport ctl (output dividing, output ratio_select, input clk_enable);
	modport div (input dividing, input ratio_select, output clk_enable);
endinterface : div_ctl_if

// File: ratio_divider.sv
module ratio_divider (
	input wire logic clk,
	input wire logic sys_rst,
	div_ctl_if.div ctl
);
	logic [clkdiv_pkg::DIV_CNT_W-1:0] count_ff;
	logic [clkdiv_pkg::DIV_CNT_W-1:0] terminal;

	function automatic logic [clkdiv_pkg::DIV_CNT_W-1:0] last_count(input logic [2:0] sel);
		unique case (sel)
			3'h0: last_count = 12'h001;
			3'h1: last_count = 12'h003;
			3'h2: last_count = 12'h007;
			3'h3: last_count = 12'h00f;
			3'h4: last_count = 12'h01f;
			3'h5: last_count = 12'h3ff;
			3'h6: last_count = 12'h7ff;
			3'h7: last_count = 12'hfff;
		endcase
	endfunction : last_count

	assign terminal = last_count(ctl.ratio_select); // [R7]

	always_ff @(posedge clk) begin
		if (sys_rst || !ctl.dividing || count_ff >= terminal) begin
			count_ff <= 12'h000;
		end else begin
			count_ff <= count_ff + 12'h001;
		end
	end

	// Undivided operation enables every cycle; divided issues one pulse per period.
	assign ctl.clk_enable = !ctl.dividing || (count_ff == terminal); // [R1] [R2]
endmodule : ratio_divider

// File: system_clock_divider_wake.sv
// Operation
// R1: Apply selected division using mode and select.
// R2: Mode 00 is normal, undivided, reset default.
// R3: Mode 01 divides now, ends on wakeup.
// R4: Delay mode, tick enabled: tick to tick.
// R5: Delay mode, masked: ends on counter overflow.
// R6: Mode field reads back divider status.
// R7: Select picks divisor 2 up to 4096.
// R8: Software exits only through the interrupt; the code also ends division on a write of mode 00.
// R9: External 0 wakes IDLE when enabled.
// R10: External 1 wakes IDLE when enabled.
// R11: Watchdog wakes IDLE when enabled.
// R12: Enabled auxiliary interrupts always wake IDLE.
// R13: Any wake during IDLE ends immediate division.
// R14: Unused bits read zero, writes ignored.
module system_clock_divider_wake (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	output logic [7:0] sfr_rdata,
	input wire logic idle_active,
	input wire logic ext0_irq,
	input wire logic ext1_irq,
	input wire logic watchdog_irq,
	input wire logic aux_irq,
	input wire logic aux_interrupt_enable,
	input wire logic millisecond_tick,
	input wire logic millisecond_interrupt_enable,
	input wire logic millisecond_overflow,
	output logic idle_wake,
	output logic dividing,
	output logic clk_enable
);
	logic ext0_wake_enable_ff;
	logic ext1_wake_enable_ff;
	logic watchdog_wake_enable_ff;
	logic [2:0] ratio_select_ff;
	clkdiv_pkg::ratio_mode_t ratio_mode_ff;
	clkdiv_pkg::ratio_mode_t nxt_ratio_mode;
	clkdiv_pkg::ratio_mode_t mode_status;
	clkdiv_pkg::delay_state_t dly_ff;
	clkdiv_pkg::delay_state_t nxt_dly;
	logic wake_seen_ff;
	logic nxt_wake_seen;
	logic [7:0] nxt_rdata;
	logic [7:0] wake_image;
	logic [7:0] ratio_image;
	logic wr_wake;
	logic wr_ratio;
	logic rd_wake;
	logic rd_ratio;
	logic [1:0] wr_mode;
	logic wr_to_normal;
	logic wr_to_immediate;
	logic wr_to_delay;
	logic wr_to_reserved;
	logic wake_ext0;
	logic wake_ext1;
	logic wake_wdt;
	logic wake_aux;
	logic wake_now;
	logic in_immediate;
	logic in_delay;
	logic delay_dividing;
	div_ctl_if dctl ();

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] reg_addr);
		reg_hit = (addr == reg_addr);
	endfunction : reg_hit

	function automatic logic code_is(
		input logic [1:0] code,
		input clkdiv_pkg::ratio_mode_t mode
	);
		code_is = (code == mode);
	endfunction : code_is

	function automatic logic wake_term(input logic enable, input logic irq);
		wake_term = enable && irq;
	endfunction : wake_term

	assign wr_wake = sfr_wr && reg_hit(sfr_addr, clkdiv_pkg::ADDR_WAKE);
	assign wr_ratio = sfr_wr && reg_hit(sfr_addr, clkdiv_pkg::ADDR_RATIO);
	assign rd_wake = sfr_rd && reg_hit(sfr_addr, clkdiv_pkg::ADDR_WAKE);
	assign rd_ratio = sfr_rd && reg_hit(sfr_addr, clkdiv_pkg::ADDR_RATIO);
	assign wr_mode = sfr_wdata[clkdiv_pkg::MODE_MSB:clkdiv_pkg::MODE_LSB];

	assign wr_to_normal = wr_ratio && code_is(wr_mode, clkdiv_pkg::MODE_NORMAL);
	assign wr_to_immediate = wr_ratio && code_is(wr_mode, clkdiv_pkg::MODE_IMMEDIATE);
	assign wr_to_delay = wr_ratio && code_is(wr_mode, clkdiv_pkg::MODE_DELAY);
	assign wr_to_reserved = wr_ratio && code_is(wr_mode, clkdiv_pkg::MODE_RESERVED);

	assign wake_ext0 = wake_term(ext0_wake_enable_ff, ext0_irq); // [R9]
	assign wake_ext1 = wake_term(ext1_wake_enable_ff, ext1_irq); // [R10]
	assign wake_wdt = wake_term(watchdog_wake_enable_ff, watchdog_irq); // [R11]
	assign wake_aux = wake_term(aux_interrupt_enable, aux_irq); // [R12]
	assign wake_now = idle_active && (wake_ext0 || wake_ext1 || wake_wdt || wake_aux); // [R13]

	assign in_immediate = (ratio_mode_ff == clkdiv_pkg::MODE_IMMEDIATE);
	assign in_delay = (ratio_mode_ff == clkdiv_pkg::MODE_DELAY);

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			idle_wake <= 1'h0;
		end else begin
			idle_wake <= wake_now; // [R13]
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ext0_wake_enable_ff <= clkdiv_pkg::WAKE_RESET[clkdiv_pkg::WAKE_EX0_BIT];
		end else if (wr_wake) begin
			ext0_wake_enable_ff <= sfr_wdata[clkdiv_pkg::WAKE_EX0_BIT]; // [R9]
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ext1_wake_enable_ff <= clkdiv_pkg::WAKE_RESET[clkdiv_pkg::WAKE_EX1_BIT];
		end else if (wr_wake) begin
			ext1_wake_enable_ff <= sfr_wdata[clkdiv_pkg::WAKE_EX1_BIT]; // [R10]
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			watchdog_wake_enable_ff <= clkdiv_pkg::WAKE_RESET[clkdiv_pkg::WAKE_WDT_BIT];
		end else if (wr_wake) begin
			watchdog_wake_enable_ff <= sfr_wdata[clkdiv_pkg::WAKE_WDT_BIT]; // [R11]
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ratio_select_ff <= clkdiv_pkg::RATIO_RESET[2:0];
		end else if (wr_ratio) begin
			ratio_select_ff <= sfr_wdata[clkdiv_pkg::SEL_MSB:0]; // [R7]
		end
	end

	// A write that clears the mode is honoured as a forced exit; software should still
	// leave through the interrupt, so the core never sees a half-taken exit. [R8]
	always_comb begin
		nxt_ratio_mode = ratio_mode_ff;
		unique case (ratio_mode_ff)
			clkdiv_pkg::MODE_NORMAL: begin
				nxt_ratio_mode = clkdiv_pkg::MODE_NORMAL; // [R2]
			end
			clkdiv_pkg::MODE_IMMEDIATE: begin
				if (wake_now) begin
					nxt_ratio_mode = clkdiv_pkg::MODE_NORMAL; // [R3] [R13]
				end
			end
			clkdiv_pkg::MODE_DELAY: begin
				if (dly_ff == clkdiv_pkg::DLY_IDLE) begin
					nxt_ratio_mode = clkdiv_pkg::MODE_NORMAL; // [R4] [R5]
				end
			end
			clkdiv_pkg::MODE_RESERVED: begin
				nxt_ratio_mode = clkdiv_pkg::MODE_NORMAL;
			end
		endcase
		if (wr_ratio && !wr_to_reserved) begin
			nxt_ratio_mode = clkdiv_pkg::ratio_mode_t'(wr_mode); // [R1]
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			ratio_mode_ff <= clkdiv_pkg::MODE_NORMAL; // [R2]
		end else begin
			ratio_mode_ff <= nxt_ratio_mode;
		end
	end

	always_comb begin
		nxt_dly = dly_ff;
		unique case (dly_ff)
			clkdiv_pkg::DLY_IDLE: begin
				if (wr_to_delay) begin
					nxt_dly = clkdiv_pkg::DLY_ARMED;
				end
			end
			clkdiv_pkg::DLY_ARMED: begin
				if (millisecond_tick) begin
					nxt_dly = clkdiv_pkg::DLY_DIVIDING; // [R4] [R5]
				end
			end
			clkdiv_pkg::DLY_DIVIDING: begin
				if (millisecond_interrupt_enable && millisecond_tick) begin
					nxt_dly = clkdiv_pkg::DLY_IDLE; // [R4]
				end else if (!millisecond_interrupt_enable && (wake_now || wake_seen_ff)) begin
					nxt_dly = clkdiv_pkg::DLY_WAIT_OVF; // [R5]
				end
			end
			clkdiv_pkg::DLY_WAIT_OVF: begin
				if (millisecond_overflow) begin
					nxt_dly = clkdiv_pkg::DLY_IDLE; // [R5]
				end
			end
		endcase
		if (wr_to_normal || wr_to_immediate) begin
			nxt_dly = clkdiv_pkg::DLY_IDLE; // [R8]
		end else if (!in_delay && !wr_to_delay) begin
			nxt_dly = clkdiv_pkg::DLY_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dly_ff <= clkdiv_pkg::DLY_IDLE;
		end else begin
			dly_ff <= nxt_dly;
		end
	end

	// A wakeup may come before the first tick; remember it for the overflow exit.
	always_comb begin
		nxt_wake_seen = wake_seen_ff;
		if (nxt_dly == clkdiv_pkg::DLY_IDLE) begin
			nxt_wake_seen = 1'h0;
		end else if (wake_now) begin
			nxt_wake_seen = 1'h1; // [R5]
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			wake_seen_ff <= 1'h0;
		end else begin
			wake_seen_ff <= nxt_wake_seen;
		end
	end

	always_comb begin
		delay_dividing = 1'h0;
		unique case (dly_ff)
			clkdiv_pkg::DLY_IDLE: begin
				delay_dividing = 1'h0;
			end
			clkdiv_pkg::DLY_ARMED: begin
				delay_dividing = 1'h0;
			end
			clkdiv_pkg::DLY_DIVIDING: begin
				delay_dividing = 1'h1; // [R4] [R5]
			end
			clkdiv_pkg::DLY_WAIT_OVF: begin
				delay_dividing = 1'h1; // [R5]
			end
		endcase
	end

	always_comb begin
		mode_status = clkdiv_pkg::MODE_NORMAL;
		unique case (ratio_mode_ff)
			clkdiv_pkg::MODE_NORMAL: begin
				mode_status = clkdiv_pkg::MODE_NORMAL;
			end
			clkdiv_pkg::MODE_IMMEDIATE: begin
				mode_status = clkdiv_pkg::MODE_IMMEDIATE; // [R6]
			end
			clkdiv_pkg::MODE_DELAY: begin
				mode_status = clkdiv_pkg::MODE_DELAY; // [R6]
			end
			clkdiv_pkg::MODE_RESERVED: begin
				mode_status = clkdiv_pkg::MODE_NORMAL;
			end
		endcase
	end

	assign wake_image = {5'h00, watchdog_wake_enable_ff, ext1_wake_enable_ff,
		ext0_wake_enable_ff} & clkdiv_pkg::WAKE_MASK; // [R14]
	assign ratio_image = {2'h0, mode_status, 1'h0, ratio_select_ff}; // [R6] [R14]

	always_comb begin
		nxt_rdata = 8'h00;
		if (rd_wake) begin
			nxt_rdata = wake_image; // [R14]
		end else if (rd_ratio) begin
			nxt_rdata = ratio_image; // [R6]
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			sfr_rdata <= 8'h00;
		end else begin
			sfr_rdata <= nxt_rdata;
		end
	end

	assign dctl.dividing = in_immediate || delay_dividing; // [R1] [R3]
	assign dctl.ratio_select = ratio_select_ff;
	assign dividing = dctl.dividing;
	assign clk_enable = dctl.clk_enable;

	ratio_divider u_div (
		.clk(clk),
		.sys_rst(sys_rst),
		.ctl(dctl)
	);
endmodule : system_clock_divider_wake

// File: clkdiv_assertions.sv
module clkdiv_checker (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_rdata,
	input wire logic idle_active,
	input wire logic idle_wake,
	input wire logic dividing,
	input wire logic clk_enable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire wr_ratio = sfr_wr && sfr_addr == 8'hc7;
	a_reset_normal: assert property ($fell(sys_rst) |-> !dividing && clk_enable)
		else $error("divider active after reset");
	a_imm_start: assert property (wr_ratio && sfr_wdata[5:4] == 2'h1 |=> dividing)
		else $error("immediate mode did not start");
	a_write_normal: assert property (wr_ratio && sfr_wdata[5:4] == 2'h0 |=> !dividing)
		else $error("normal mode still dividing");
	a_undiv_enable: assert property (!dividing |-> clk_enable)
		else $error("clock held while undivided");
	a_pulse_spacing: assert property (dividing && clk_enable |=> !clk_enable || !dividing)
		else $error("divided enable pulses too close");
	a_wake_idle: assert property (!idle_active |=> !idle_wake)
		else $error("wake outside idle");
	a_unused_zero: assert property (sfr_rd && sfr_addr == 8'hc7 |=> sfr_rdata[7:6] == 2'h0 && !sfr_rdata[3])
		else $error("unused ratio bits not zero");
	a_unmapped_zero: assert property (sfr_rd && sfr_addr != 8'hc6 && sfr_addr != 8'hc7 |=> sfr_rdata == 8'h00)
		else $error("unmapped read not zero");
endmodule : clkdiv_checker
bind system_clock_divider_wake clkdiv_checker chk (.clk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr,
	.sfr_rd, .sfr_rdata, .idle_active, .idle_wake, .dividing, .clk_enable);

// File: system_clock_divider_wake_bench.sv
module system_clock_divider_wake_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, sys_rst = 1, sfr_wr = 0, sfr_rd = 0, idle_active = 0, aux_interrupt_enable = 0;
	logic millisecond_tick = 0, millisecond_interrupt_enable = 0, millisecond_overflow = 0;
	logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
	logic [3:0] irq = 4'h0;
	logic idle_wake, dividing, clk_enable;
	int miscompares = 0, num_checks = 0, cycles = 0;
	system_clock_divider_wake dut (.clk, .sys_rst, .sfr_addr, .sfr_wdata, .sfr_wr, .sfr_rd,
		.sfr_rdata, .idle_active, .ext0_irq(irq[0]), .ext1_irq(irq[1]), .watchdog_irq(irq[2]),
		.aux_irq(irq[3]), .aux_interrupt_enable, .millisecond_tick, .millisecond_interrupt_enable,
		.millisecond_overflow, .idle_wake, .dividing, .clk_enable);
	initial forever #5 clk = ~clk;
	// The whole run needs about 15000 cycles; over twice that means a hang.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			miscompares = miscompares + 1;
			stop_test();
		end
	end
	task stop_test();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : stop_test
	task chk(input string n, input logic [12:0] e, input logic [12:0] g);
		num_checks++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task step();
		@(posedge clk);
		#1;
	endtask : step
	task wr(input logic [7:0] a, input logic [7:0] d);
		step();
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1;
		step();
		sfr_wr = 0;
	endtask : wr
	task rdchk(input logic [7:0] a, input logic [7:0] e);
		step();
		sfr_addr = a;
		sfr_rd = 1;
		step();
		sfr_rd = 0;
		chk("rdata", e, sfr_rdata);
	endtask : rdchk
	task wake(input logic [3:0] src, input logic e);
		step();
		idle_active = 1;
		irq = src;
		step();
		chk("idle_wake", e, idle_wake);
		irq = 4'h0;
		idle_active = 0;
	endtask : wake
	task ms(input logic t, input logic o);
		step();
		millisecond_tick = t;
		millisecond_overflow = o;
		step();
		millisecond_tick = 0;
		millisecond_overflow = 0;
	endtask : ms
	task t_regs();
		rdchk(8'hc6, 8'h00);
		rdchk(8'hc7, 8'h00);
		wr(8'hc6, 8'hff);
		rdchk(8'hc6, 8'h07);
		rdchk(8'hc5, 8'h00);
		wr(8'hc7, 8'hff);
		rdchk(8'hc7, 8'h07);
		chk("dividing", 0, dividing);
		$display("regs done");
	endtask : t_regs
	task t_wake();
		for (int i = 0; i < 4; i++) begin
			wr(8'hc6, 8'h00);
			wr(8'hc7, 8'h10);
			wake(4'h1 << i, 0);
			chk("dividing", 1, dividing);
			wr(8'hc6, 8'h01 << i);
			aux_interrupt_enable = (i == 3);
			wake(4'h1 << i, 1);
			chk("dividing", 0, dividing);
		end
		$display("wake done");
	endtask : t_wake
	task t_ratio();
		int n;
		for (int s = 0; s < 8; s++) begin
			wr(8'hc7, 8'h10 | s[7:0]);
			n = 0;
			while (!clk_enable && n < 5000) begin
				step();
				n++;
			end
			n = 0;
			do begin
				step();
				n++;
			end while (!clk_enable && n < 5000);
			chk("divisor", (s < 5) ? (2 << s) : (1024 << (s - 5)), n[12:0]);
			rdchk(8'hc7, 8'h10 | s[7:0]);
			wake(4'h8, 1);
		end
		$display("ratio done");
	endtask : t_ratio
	task t_delay();
		millisecond_interrupt_enable = 1;
		wr(8'hc7, 8'h20);
		chk("dividing", 0, dividing);
		ms(1, 0);
		chk("dividing", 1, dividing);
		rdchk(8'hc7, 8'h20);
		ms(1, 0);
		chk("dividing", 0, dividing);
		rdchk(8'hc7, 8'h00);
		millisecond_interrupt_enable = 0;
		wr(8'hc7, 8'h20);
		ms(1, 0);
		ms(1, 1);
		chk("dividing", 1, dividing);
		wake(4'h8, 1);
		ms(0, 1);
		chk("dividing", 0, dividing);
		wr(8'hc7, 8'h20);
		wake(4'h8, 1);
		ms(1, 0);
		chk("dividing", 1, dividing);
		ms(0, 1);
		chk("dividing", 0, dividing);
		wr(8'hc7, 8'h20);
		ms(1, 0);
		wr(8'hc7, 8'h00);
		chk("dividing", 0, dividing);
		rdchk(8'hc7, 8'h00);
		$display("delay done");
	endtask : t_delay
	initial begin
		repeat (4) @(posedge clk);
		#1 sys_rst = 0;
		t_regs();
		t_wake();
		t_ratio();
		t_delay();
		stop_test();
	end
endmodule : system_clock_divider_wake_bench
